//--- core/rnp_pkg.sv
`default_nettype none
package rnp_pkg;

    // Reset input must stay low this long (ns) to be taken as a reset
    localparam int RESET_MIN_NS = 500;
    localparam int CLK_PERIOD_NS = 4;
    // Least time rounds up to whole cycles
    localparam int RESET_MIN_CYC =
        (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Internal reset sequence length in cycles
    localparam int SEQ_LEN_CYC = 64;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CNT_W-1:0] RESET_MIN_CNT = CNT_W'(RESET_MIN_CYC);
    localparam logic [CNT_W-1:0] SEQ_LEN_CNT = CNT_W'(SEQ_LEN_CYC);

    // Configuration bits of the system configuration register
    typedef struct packed {
        logic bidir_reset_enable;
        logic powerdown_config_bit;
    } rnp_cfg_s;

    // Reset and power-down requests coming from the CPU core
    typedef struct packed {
        logic sw_reset;
        logic wdt_reset;
        logic end_init_instruction;
        logic powerdown_instruction;
    } rnp_cpu_req_s;

    // Sequencer states
    typedef enum logic [1:0] {
        RNP_RUN,
        RNP_SEQ,
        RNP_INIT
    } rnp_state_e;

endpackage : rnp_pkg
`default_nettype wire

//--- core/rnp_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for one pin level
module rnp_sync
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // Level
    input wire logic async_i,
    output logic sync_o
);
    // Only the second flop reads the first
    logic meta_reg;
    logic sync_reg;

    // Pins idle high, so reset to high
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
        end
        else
        begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;
endmodule : rnp_sync
`default_nettype wire

//--- core/rnp_reset_nmi_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Long enough low reset input enters reset
// - Bidir enable drives reset pin during a sequence started by a reset source, not the power-on one
// - Any hardware, software, watchdog reset lowers indication
// - Indication stays low until end-init executes
// - Falling NMI edge vectors CPU to trap, except during the reset sequence
// - Power-down only with NMI low, config zero
module rnp_reset_nmi_ctrl
    import rnp_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // Reset pin, split into in, out and enable
    input wire logic reset_input_i,
    output logic reset_input_o,
    output logic reset_input_oe_n_o,
    // Reset indication pin, active low
    output logic reset_indication_output_n_o,
    // Non-maskable interrupt pin
    input wire logic nmi_n_i,
    // Configuration and CPU requests
    input wire rnp_cfg_s cfg_i,
    input wire rnp_cpu_req_s cpu_req_i,
    // Towards the CPU core
    output logic core_reset_o,
    output logic nmi_trap_o,
    output logic powerdown_o
);
    // Synchronised pin levels
    logic rst_pin_sync;
    logic nmi_sync;

    // Sequencer state
    rnp_state_e state_reg, state_next;
    logic [CNT_W-1:0] low_cnt_reg, low_cnt_next;
    logic [CNT_W-1:0] seq_cnt_reg, seq_cnt_next;
    logic nmi_prev_reg, nmi_prev_next;
    // Output flops
    logic drive_reg, drive_next;
    // Pin enable kept in its own flop so the output needs no gate
    logic oe_n_reg, oe_n_next;
    logic ind_n_reg, ind_n_next;
    logic core_rst_reg, core_rst_next;
    logic trap_reg, trap_next;
    logic pd_reg, pd_next;
    // Flags derived from the pin filter
    logic pin_reset;

    // Reset pin synchroniser
    rnp_sync u_rst_sync
    (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .async_i(reset_input_i),
        .sync_o(rst_pin_sync)
    );

    // NMI pin synchroniser
    rnp_sync u_nmi_sync
    (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .async_i(nmi_n_i),
        .sync_o(nmi_sync)
    );

    // Pin counts as reset once the low run reaches the minimum
    assign pin_reset = (low_cnt_reg == RESET_MIN_CNT);

    // Next-state logic for the whole controller
    always_comb
    begin
        state_next = state_reg;
        seq_cnt_next = seq_cnt_reg;
        drive_next = drive_reg;
        ind_n_next = ind_n_reg;
        core_rst_next = core_rst_reg;
        pd_next = pd_reg;
        nmi_prev_next = nmi_sync;
        // Low-time counter saturates; our own drive is ignored so
        // the bidir mode cannot hold itself in reset forever
        if (rst_pin_sync || drive_reg)
        begin
            low_cnt_next = CNT_ZERO;
        end
        else if (low_cnt_reg != RESET_MIN_CNT)
        begin
            low_cnt_next = low_cnt_reg + CNT_ONE;
        end
        else
        begin
            low_cnt_next = low_cnt_reg;
        end
        // Falling edge from two synchronised samples, one-cycle pulse
        trap_next = nmi_prev_reg && !nmi_sync
            && (state_reg == RNP_RUN || state_reg == RNP_INIT);
        // Any reset source restarts the sequence; it wins over all
        if (pin_reset || cpu_req_i.sw_reset || cpu_req_i.wdt_reset)
        begin
            state_next = RNP_SEQ;
            seq_cnt_next = CNT_ZERO;
            core_rst_next = 1'b1;
            ind_n_next = 1'b0;
            drive_next = cfg_i.bidir_reset_enable;
            pd_next = 1'b0;
            trap_next = 1'b0;
        end
        else
        begin
            case (state_reg)
                RNP_SEQ:
                begin
                    // Internal reset sequence runs a fixed length
                    if (seq_cnt_reg == SEQ_LEN_CNT - CNT_ONE)
                    begin
                        state_next = RNP_INIT;
                        core_rst_next = 1'b0;
                        drive_next = 1'b0;
                    end
                    else
                    begin
                        seq_cnt_next = seq_cnt_reg + CNT_ONE;
                    end
                end
                RNP_INIT:
                begin
                    // Indication held low until end of init
                    if (cpu_req_i.end_init_instruction)
                    begin
                        state_next = RNP_RUN;
                        ind_n_next = 1'b1;
                    end
                end
                RNP_RUN:
                begin
                    // Power-down gated by the NMI level when config zero
                    if (cpu_req_i.powerdown_instruction
                        && !cfg_i.powerdown_config_bit && !nmi_sync)
                    begin
                        pd_next = 1'b1;
                    end
                    else if (nmi_prev_reg && !nmi_sync)
                    begin
                        // A falling NMI edge wakes the part out of power-down
                        pd_next = 1'b0;
                    end
                end
                default:
                begin
                    state_next = RNP_SEQ;
                    seq_cnt_next = CNT_ZERO;
                end
            endcase
        end
        // Enable is the inverse of the final drive decision
        oe_n_next = !drive_next;
    end

    // Registers only; power-on comes up inside the reset sequence
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_reg <= RNP_SEQ;
            low_cnt_reg <= CNT_ZERO;
            seq_cnt_reg <= CNT_ZERO;
            nmi_prev_reg <= 1'b1;
            drive_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            ind_n_reg <= 1'b0;
            core_rst_reg <= 1'b1;
            trap_reg <= 1'b0;
            pd_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            low_cnt_reg <= low_cnt_next;
            seq_cnt_reg <= seq_cnt_next;
            nmi_prev_reg <= nmi_prev_next;
            drive_reg <= drive_next;
            oe_n_reg <= oe_n_next;
            ind_n_reg <= ind_n_next;
            core_rst_reg <= core_rst_next;
            trap_reg <= trap_next;
            pd_reg <= pd_next;
        end
    end

    // Open-drain style: drive low, enable active low
    assign reset_input_o = 1'b0;
    assign reset_input_oe_n_o = oe_n_reg;
    assign reset_indication_output_n_o = ind_n_reg;
    assign core_reset_o = core_rst_reg;
    assign nmi_trap_o = trap_reg;
    assign powerdown_o = pd_reg;

    // Minimum low time leads into reset
    property p_pin_reset;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        pin_reset |=> core_rst_reg && !ind_n_reg;
    endproperty
    a_pin_reset: assert property (p_pin_reset)
        else $error("pin reset not taken");

    // Drive holds its value throughout the sequence
    property p_bidir;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        (state_reg == RNP_SEQ && core_rst_reg) |-> (drive_reg ==
            $past(drive_reg) || $past(state_reg) != RNP_SEQ);
    endproperty
    a_bidir: assert property (p_bidir)
        else $error("reset pin drive changed mid sequence");

    // Software and watchdog resets lower the indication
    property p_sw_reset;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        (cpu_req_i.sw_reset || cpu_req_i.wdt_reset) |=> !ind_n_reg;
    endproperty
    a_sw_reset: assert property (p_sw_reset)
        else $error("indication not low after reset");

    // Indication rises only on end of init
    property p_release;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        $rose(ind_n_reg) |-> $past(cpu_req_i.end_init_instruction)
            && $past(state_reg) == RNP_INIT;
    endproperty
    a_release: assert property (p_release)
        else $error("indication released without end of init");

    // Edge sequence on the synchronised pin
    sequence s_nmi_fall;
        nmi_prev_reg && !nmi_sync && state_reg == RNP_RUN
            && !pin_reset && !cpu_req_i.sw_reset && !cpu_req_i.wdt_reset;
    endsequence
    property p_trap;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        s_nmi_fall |=> trap_reg ##1 !trap_reg;
    endproperty
    a_trap: assert property (p_trap)
        else $error("nmi trap not raised on falling edge");

    // Power-down needs NMI low
    property p_pd;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        $rose(pd_reg) |-> !$past(nmi_sync)
            && !$past(cfg_i.powerdown_config_bit);
    endproperty
    a_pd: assert property (p_pd)
        else $error("power-down entered with nmi high");

    // Trap never without an edge
    property p_trap_cause;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        trap_reg |-> $past(nmi_prev_reg) && !$past(nmi_sync);
    endproperty
    a_trap_cause: assert property (p_trap_cause)
        else $error("trap without falling edge");

    // Drive released when sequence ends
    property p_drive_end;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        (state_reg == RNP_INIT) |-> !drive_reg && !core_rst_reg;
    endproperty
    a_drive_end: assert property (p_drive_end)
        else $error("reset pin still driven after sequence");
endmodule : rnp_reset_nmi_ctrl
`default_nettype wire

//--- testbench/rnp_board_model.sv
`timescale 1ns/1ps
`default_nettype none
// Board side: reset button, NMI source, pull-ups on both pins
module rnp_board_model
#(
    // Slow board edge on the NMI line, off-phase to the clock
    parameter int NMI_SLEW_NS = 3
)
(
    // Board requests
    input wire logic hold_reset_i,
    input wire logic nmi_low_i,
    // Device side of the reset pin
    input wire logic dev_reset_i,
    input wire logic dev_reset_oe_n_i,
    // Resolved pin levels
    output logic reset_pin_o,
    output logic nmi_pin_o
);
    // Wired line with pull-up: any party pulling low wins
    assign reset_pin_o = !(hold_reset_i
        || (!dev_reset_oe_n_i && !dev_reset_i));
    // Pulled high when idle, so an unused NMI never fires
    assign #(NMI_SLEW_NS) nmi_pin_o = !nmi_low_i;
endmodule : rnp_board_model
`default_nettype wire

//--- testbench/reset_nmi_powerdown_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module reset_nmi_powerdown_control_tb;
    import rnp_pkg::*;
    // Bench stimulus
    logic sys_clk_i;
    logic arst_n_i;
    logic hold_rst;
    logic nmi_low;
    rnp_cfg_s cfg;
    rnp_cpu_req_s req;
    // Pins and design outputs
    logic rst_pin;
    logic nmi_pin;
    logic rst_drv;
    logic rst_oe_n;
    logic ind_n;
    logic core_rst;
    logic trap;
    logic pdown;
    int fail_count;
    int check_count;
    int cycles;
    int n;

    rnp_reset_nmi_ctrl uut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
        .reset_input_i(rst_pin), .reset_input_o(rst_drv),
        .reset_input_oe_n_o(rst_oe_n), .reset_indication_output_n_o(ind_n),
        .nmi_n_i(nmi_pin), .cfg_i(cfg), .cpu_req_i(req),
        .core_reset_o(core_rst), .nmi_trap_o(trap), .powerdown_o(pdown));
    rnp_board_model board (.hold_reset_i(hold_rst), .nmi_low_i(nmi_low),
        .dev_reset_i(rst_drv), .dev_reset_oe_n_i(rst_oe_n),
        .reset_pin_o(rst_pin), .nmi_pin_o(nmi_pin));

    // Free-running clock
    initial
    begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    // Hang guard, well above the expected run length
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            fail_count++;
            summarize();
        end
    end

    task automatic summarize();
        if (fail_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize

    task automatic check(input logic got, input logic exp, input string m);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : check

    task automatic tick(input int k);
        repeat (k) @(negedge sys_clk_i);
    endtask : tick

    // One-cycle CPU request
    task automatic pulse(input rnp_cpu_req_s r);
        @(negedge sys_clk_i);
        req = r;
        @(negedge sys_clk_i);
        req = '0;
    endtask : pulse

    // Sequence must end in time; indication only freed by end-init
    task automatic finish_init();
        n = 0;
        while (core_rst !== 1'b0 && n < SEQ_LEN_CYC + 8)
        begin
            tick(1);
            n++;
        end
        check(core_rst, 1'b0, "sequence did not end");
        tick(10);
        check(ind_n, 1'b0, "indication freed early");
        pulse('{0, 0, 1, 0});
        tick(1);
        check(ind_n, 1'b1, "indication not freed");
    endtask : finish_init

    task automatic t_power_on();
        check(core_rst, 1'b1, "no reset after power-on");
        check(ind_n, 1'b0, "indication high in reset");
        check(rst_oe_n, 1'b1, "pin driven without bidir");
        finish_init();
    endtask : t_power_on

    task automatic t_pin_reset();
        hold_rst = 1'b1;
        tick(60);
        hold_rst = 1'b0;
        tick(5);
        check(core_rst, 1'b0, "short low taken as reset");
        cfg.bidir_reset_enable = 1'b1;
        hold_rst = 1'b1;
        tick(RESET_MIN_CYC + 6);
        check(core_rst, 1'b1, "long low not taken");
        check(ind_n, 1'b0, "indication high in reset");
        check(rst_oe_n, 1'b0, "pin not driven");
        check(rst_pin, 1'b0, "pin not low");
        check(rst_drv, 1'b0, "driven level not low");
        hold_rst = 1'b0;
        tick(SEQ_LEN_CYC / 2);
        check(rst_pin, 1'b0, "pin released mid-sequence");
        finish_init();
        check(rst_oe_n, 1'b1, "pin held after sequence");
        cfg.bidir_reset_enable = 1'b0;
    endtask : t_pin_reset

    task automatic t_soft_resets();
        pulse('{1, 0, 0, 0});
        tick(2);
        check(core_rst, 1'b1, "software reset ignored");
        check(ind_n, 1'b0, "indication high, sw reset");
        pulse('{0, 0, 1, 0});
        finish_init();
        pulse('{0, 1, 0, 0});
        tick(2);
        check(core_rst, 1'b1, "watchdog reset ignored");
        check(ind_n, 1'b0, "indication high, wdt reset");
        finish_init();
    endtask : t_soft_resets

    task automatic t_nmi();
        nmi_low = 1'b1;
        n = 0;
        repeat (8)
        begin
            tick(1);
            if (trap === 1'b1)
                n++;
        end
        check(n == 1, 1'b1, "trap not one pulse");
        nmi_low = 1'b0;
        tick(4);
    endtask : t_nmi

    task automatic t_powerdown();
        pulse('{0, 0, 0, 1});
        tick(2);
        check(pdown, 1'b0, "power-down with NMI high");
        cfg.powerdown_config_bit = 1'b1;
        nmi_low = 1'b1;
        tick(6);
        pulse('{0, 0, 0, 1});
        tick(2);
        check(pdown, 1'b0, "power-down with config set");
        cfg.powerdown_config_bit = 1'b0;
        pulse('{0, 0, 0, 1});
        tick(2);
        check(pdown, 1'b1, "no power-down, NMI low");
        nmi_low = 1'b0;
        tick(6);
        check(pdown, 1'b1, "woke on NMI rise");
        nmi_low = 1'b1;
        tick(8);
        check(pdown, 1'b0, "no wake on NMI fall");
        nmi_low = 1'b0;
        tick(4);
    endtask : t_powerdown

    // Main sequence
    initial
    begin
        fail_count = 0;
        check_count = 0;
        cycles = 0;
        arst_n_i = 1'b0;
        hold_rst = 1'b0;
        nmi_low = 1'b0;
        // Software side: bidir enable and power-down config bit both cleared
        cfg = '0;
        req = '0;
        tick(12);
        arst_n_i = 1'b1;
        tick(2);
        t_power_on();
        t_pin_reset();
        t_soft_resets();
        t_nmi();
        t_powerdown();
        summarize();
    end
endmodule : reset_nmi_powerdown_control_tb
`default_nettype wire
